// [tb/aofc_rx_model.sv]
`timescale 1ns/1ps
`default_nettype none
module aofc_rx_model
	import aofc_pkg::*;
(
	// Clock and reset.
	input  wire logic              clk,
	input  wire logic              srst,
	// Stall request from the bench.
	input  wire logic              hold,
	// Link from the converter.
	input  wire logic [WORD_W-1:0] data_out,
	input  wire logic              fwd_clock_pos,
	output logic                   rx_ready,
	// Stabilizer status seen by the receiver.
	input  wire logic              dcs_enabled,
	input  wire logic              dcs_locked,
	// Captured words.
	output logic [WORD_W-1:0]      last_word,
	output int                     word_count,
	output int                     settled_count
);
	logic pos_q;

	always_ff @(posedge clk) begin
		rx_ready <= !hold;
	end

	// Words are taken on the forwarded clock, never on the local clock alone.
	always_ff @(posedge clk) begin
		if (srst) begin
			pos_q      <= 1'b1;
			word_count <= 0;
			last_word  <= 8'h00;
		end else begin
			pos_q <= fwd_clock_pos;
			if (fwd_clock_pos && !pos_q) begin
				last_word  <= data_out;
				word_count <= word_count + 1;
			end
		end
	end

	// A word latched while the stabilizer is still settling is not trusted.
	always_ff @(posedge clk) begin
		if (srst) begin
			settled_count <= 0;
		end else if (fwd_clock_pos && !pos_q && (!dcs_enabled || dcs_locked)) begin
			settled_count <= settled_count + 1;
		end
	end
endmodule
`default_nettype wire

// [tb/test_aofc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module test_aofc_top
	import aofc_pkg::*;
;
	logic              clk = 1'b0;
	logic              srst = 1'b1;
	logic              sample_clk = 1'b0;
	logic [MV_W-1:0]   analog_in_pos = 16'h0000;
	logic [MV_W-1:0]   analog_in_neg = 16'h0000;
	logic [7:0]        format_stabilizer_select = 8'hFF;
	logic              rx_ready;
	logic              hold = 1'b0;
	logic [WORD_W-1:0] data_out;
	logic [WORD_W-1:0] last_word;
	logic              fwd_clock_pos;
	logic              fwd_clock_neg;
	logic              twos_mode;
	logic              dcs_enabled;
	logic              dcs_locked;
	logic              sample_stall;
	int                word_count;
	int                settled_count;
	int                bad_count = 0;
	int                num_checks = 0;

	always #50 clk = ~clk;

	aofc_top aofc_top_inst (.clk(clk), .srst(srst), .sample_clk(sample_clk),
		.analog_in_pos(analog_in_pos), .analog_in_neg(analog_in_neg),
		.format_stabilizer_select(format_stabilizer_select), .rx_ready(rx_ready),
		.data_out(data_out), .fwd_clock_pos(fwd_clock_pos), .fwd_clock_neg(fwd_clock_neg),
		.twos_mode(twos_mode), .dcs_enabled(dcs_enabled), .dcs_locked(dcs_locked),
		.sample_stall(sample_stall));

	aofc_rx_model aofc_rx_model_inst (.clk(clk), .srst(srst), .hold(hold),
		.data_out(data_out), .fwd_clock_pos(fwd_clock_pos), .rx_ready(rx_ready),
		.dcs_enabled(dcs_enabled), .dcs_locked(dcs_locked),
		.last_word(last_word), .word_count(word_count), .settled_count(settled_count));

	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [7:0] code_of(input int mv, input bit twos);
		int c;
		c = (mv >= 0) ? mv / 4 : -((3 - mv) / 4);
		c = c + 128;
		if (c > 255) c = 255;
		if (c < 0) c = 0;
		return twos ? 8'(c ^ 128) : 8'(c);
	endfunction

	// One encode period of 8 clk when called back to back; the leading wait closes the low half.
	task automatic pulse(input int mv);
		@(negedge clk);
		analog_in_pos = 16'(mv);
		sample_clk = 1'b1;
		repeat (4) @(negedge clk);
		sample_clk = 1'b0;
		repeat (3) @(negedge clk);
	endtask

	task automatic wait_word(input int n, input logic [7:0] exp);
		int i;
		for (i = 0; i < 40 && word_count == n; i++) @(negedge clk);
		if (word_count == n) begin
			bad_count++;
			stop_test();
		end
		check("word", last_word, exp);
		check("fwd_neg", 8'(fwd_clock_neg), 8'(!fwd_clock_pos));
	endtask

	task automatic xfer(input int mv, input bit twos);
		int n;
		n = word_count;
		pulse(mv);
		wait_word(n, code_of(mv, twos));
	endtask

	// Every select band, with the coding table in the format it picks.
	task automatic scen_formats();
		logic [7:0] lvl [4] = '{8'hFF, 8'hAA, 8'h55, 8'h00};
		int mv [8] = '{0, 4, -4, 508, 512, 600, -508, -600};
		int b;
		int k;
		for (b = 0; b < 4; b++) begin
			@(negedge clk);
			format_stabilizer_select = lvl[b];
			repeat (5) @(negedge clk);
			check("twos_mode", 8'(twos_mode), 8'(b >= 2));
			check("dcs_enabled", 8'(dcs_enabled), 8'(b == 1 || b == 2));
			for (k = 0; k < 8; k++) xfer(mv[k], b >= 2);
		end
	endtask

	// Receiver stalls: two words are kept, the third is dropped.
	task automatic scen_stall();
		int n;
		bit seen;
		@(negedge clk);
		format_stabilizer_select = 8'hAA;
		hold = 1'b1;
		repeat (6) @(negedge clk);
		n = word_count;
		seen = 0;
		pulse(40);
		pulse(80);
		pulse(120);
		repeat (4) begin
			@(negedge clk);
			seen |= sample_stall;
		end
		check("sample_stall", 8'(seen), 8'h01);
		check("held_count", 8'(word_count - n), 8'h00);
		hold = 1'b0;
		wait_word(n, code_of(40, 0));
		wait_word(n + 1, code_of(80, 0));
		repeat (30) @(negedge clk);
		check("dropped", 8'(word_count - n), 8'h02);
	endtask

	// Stabilizer lock at the nominal rate, loss when the sample clock stops.
	task automatic scen_lock();
		int s;
		@(negedge clk);
		format_stabilizer_select = 8'hAA;
		repeat (5) @(negedge clk);
		s = settled_count;
		pulse(0);
		check("unsettled", 8'(settled_count - s), 8'h00);
		repeat (9) pulse(0);
		check("locked", 8'(dcs_locked), 8'h01);
		s = settled_count;
		pulse(0);
		check("settled", 8'(settled_count - s), 8'h01);
		repeat (30) @(negedge clk);
		check("unlocked", 8'(dcs_locked), 8'h00);
	endtask

	initial begin
		repeat (12) @(negedge clk);
		srst = 1'b0;
		repeat (2) @(negedge clk);
		scen_formats();
		scen_stall();
		scen_lock();
		stop_test();
	end
endmodule
`default_nettype wire

// [verilog/aofc_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module aofc_fifo
	import aofc_pkg::*;
#(
	parameter int W     = WORD_W,
	parameter int DEPTH = BUF_DEPTH
) (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         srst,
	// Filling side.
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Draining side.
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0]  mem_q [DEPTH];
	logic [PW-1:0] wr_ptr_q;
	logic [PW-1:0] rd_ptr_q;
	logic [CW-1:0] count_q;
	logic          push;
	logic          pop;

	assign in_ready  = (count_q != CW'(DEPTH));
	assign out_valid = (count_q != '0);
	assign out_data  = mem_q[rd_ptr_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			count_q <= '0;
		end else if (push && !pop) begin
			count_q <= count_q + 1'b1;
		end else if (pop && !push) begin
			count_q <= count_q - 1'b1;
		end
	end
endmodule
`default_nettype wire

// [verilog/aofc_pkg.sv]
`default_nettype none
package aofc_pkg;
	// Output word, buffer, input bus and difference shape.
	localparam int          WORD_W        = 8;
	localparam int          BUF_DEPTH     = 2;
	localparam int          MV_W          = 16;
	localparam int          DIFF_W        = MV_W + 1;

	// Timing base.
	localparam int          CLK_PERIOD_NS = 100;

	// Coding: one step is 4 mV, full scale is +/-512 mV.
	localparam int          LSB_SHIFT     = 2;
	localparam logic [7:0]  CODE_MID      = 8'h80;
	localparam logic [7:0]  CODE_MAX      = 8'hFF;
	localparam logic [7:0]  CODE_MIN      = 8'h00;
	localparam int          CODE_SPAN     = 256;

	// Four-level select pin, sampled as a fraction of the supply (255 = full supply).
	localparam logic [7:0]  BAND_TOP_MIN  = 8'hD5;
	localparam logic [7:0]  BAND_HALF_MIN = 8'h80;
	localparam logic [7:0]  BAND_LOW_MIN  = 8'h2B;

	// Forwarded clock shape, in clk cycles.
	localparam logic [1:0]  FWD_SETUP_CYC = 2'h2;
	localparam logic [1:0]  FWD_HIGH_CYC  = 2'h2;

	// Stabilizer settle wait and the slowest sample period it works at.
	localparam int          DCS_WAIT_NS   = 5000;
	localparam int          DCS_WAIT_CYC  = (DCS_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0]  DCS_MAX_PER   = 8'h10;
	localparam logic [7:0]  PER_RST       = 8'h00;
	localparam logic [6:0]  LOCK_RST      = 7'h00;

	typedef enum logic [1:0] {
		AOFC_BAND_BOTTOM,
		AOFC_BAND_LOW,
		AOFC_BAND_HIGH,
		AOFC_BAND_TOP
	} aofc_band_t;

	typedef enum logic [1:0] {
		AOFC_ST_IDLE,
		AOFC_ST_SETUP,
		AOFC_ST_HIGH
	} aofc_state_t;
endpackage
`default_nettype wire

// [verilog/aofc_top.sv]
// Operation
// [R1] Upper two select-pin bands give offset binary, lower two give twos complement.
// [R2] Stabilizer is on in the two middle bands, off at top and bottom.
// [R3] Zero differential input gives midscale, 1000 0000 or 0000 0000.
// [R4] Input at or above +full scale saturates at 1111 1111 or 0111 1111.
// [R5] Input at or below -full scale saturates at 0000 0000 or 1000 0000.
// [R6] One code step per 4 mV; just above midscale is 1000 0001 or 0000 0001.
// [R7] A differential forwarded clock travels with the parallel data word.
// [R8] Forwarded clock and data keep a fixed, matched relation.
// [R9] Receiver latches data on the forwarded clock, not its own clock.
// [R10] Receiver ignores words until stabilizer settles 5 us after a rate increase.
// [R11] Stabilizer locks to sample clock rising edges; not needed below minimum rate.
// [R12] Twos complement is offset binary with MSB inverted; one word per sample; a sample that finds the buffer full gives no word.
`timescale 1ns/1ps
`default_nettype none
module aofc_top
	import aofc_pkg::*;
(
	// Clock and reset.
	input  wire logic              clk,
	input  wire logic              srst,
	// Converter inputs from outside this clock domain.
	input  wire logic              sample_clk,
	input  wire logic [MV_W-1:0]   analog_in_pos,
	input  wire logic [MV_W-1:0]   analog_in_neg,
	input  wire logic [7:0]        format_stabilizer_select,
	// Receiver side.
	input  wire logic              rx_ready,
	output logic [WORD_W-1:0]      data_out,
	output logic                   fwd_clock_pos,
	output logic                   fwd_clock_neg,
	// Status.
	output logic                   twos_mode,
	output logic                   dcs_enabled,
	output logic                   dcs_locked,
	output logic                   sample_stall
);
	logic [2:0]          sclk_sync_q;
	logic [MV_W-1:0]     pos_m_q;
	logic [MV_W-1:0]     pos_s_q;
	logic [MV_W-1:0]     neg_m_q;
	logic [MV_W-1:0]     neg_s_q;
	logic [7:0]          sel_m_q;
	logic [7:0]          sel_s_q;
	logic [1:0]          rdy_sync_q;
	logic                sample_rise;
	logic                twos_q;
	logic                dcs_en_q;
	logic                dcs_locked_q;
	logic [7:0]          per_cnt_q;
	logic [7:0]          last_per_q;
	logic [6:0]          lock_cnt_q;
	logic signed [DIFF_W-1:0] diff;
	logic signed [DIFF_W-1:0] code_s;
	logic [WORD_W-1:0]   bin_word;
	logic [WORD_W-1:0]   word_c;
	logic                buf_in_ready;
	logic                buf_out_valid;
	logic                buf_pop;
	logic [WORD_W-1:0]   buf_out_data;
	aofc_state_t         state_q;
	logic [1:0]          phase_cnt_q;
	logic [WORD_W-1:0]   data_q;
	logic                fwd_pos_q;
	logic                fwd_neg_q;
	logic                stall_q;

	function automatic aofc_band_t decode_band(input logic [7:0] level);
		if (level >= BAND_TOP_MIN) begin
			return AOFC_BAND_TOP;
		end else if (level >= BAND_HALF_MIN) begin
			return AOFC_BAND_HIGH;
		end else if (level >= BAND_LOW_MIN) begin
			return AOFC_BAND_LOW;
		end
		return AOFC_BAND_BOTTOM;
	endfunction

	// Every outside input passes two flops; the third sample clock flop only feeds the edge detector.
	always_ff @(posedge clk) begin
		if (srst) begin
			sclk_sync_q <= 3'h0;
			rdy_sync_q  <= 2'h0;
		end else begin
			sclk_sync_q <= {sclk_sync_q[1:0], sample_clk};
			rdy_sync_q  <= {rdy_sync_q[0], rx_ready};
		end
	end

	// The analog and select buses are quasi-static relative to clk, so per-bit sync is acceptable.
	always_ff @(posedge clk) begin
		pos_m_q <= analog_in_pos;
		pos_s_q <= pos_m_q;
		neg_m_q <= analog_in_neg;
		neg_s_q <= neg_m_q;
		sel_m_q <= format_stabilizer_select;
		sel_s_q <= sel_m_q;
	end

	assign sample_rise = sclk_sync_q[1] && !sclk_sync_q[2]; // R11

	always_ff @(posedge clk) begin
		if (srst) begin
			twos_q   <= 1'b0;
			dcs_en_q <= 1'b0;
		end else begin
			unique case (decode_band(sel_s_q))
				AOFC_BAND_TOP: begin
					twos_q   <= 1'b0; // R1
					dcs_en_q <= 1'b0; // R2
				end
				AOFC_BAND_HIGH: begin
					twos_q   <= 1'b0; // R1
					dcs_en_q <= 1'b1; // R2
				end
				AOFC_BAND_LOW: begin
					twos_q   <= 1'b1; // R1
					dcs_en_q <= 1'b1; // R2
				end
				AOFC_BAND_BOTTOM: begin
					twos_q   <= 1'b1; // R1
					dcs_en_q <= 1'b0; // R2
				end
			endcase
		end
	end

	// Stabilizer model: locks after a steady run of rising edges; a shorter period restarts the wait.
	always_ff @(posedge clk) begin
		if (srst) begin
			per_cnt_q  <= PER_RST;
			last_per_q <= PER_RST;
		end else if (sample_rise) begin
			per_cnt_q  <= 8'h01;
			last_per_q <= per_cnt_q;
		end else if (per_cnt_q != 8'hFF) begin
			per_cnt_q <= per_cnt_q + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			lock_cnt_q   <= LOCK_RST;
			dcs_locked_q <= 1'b0;
		end else if (!dcs_en_q || per_cnt_q > DCS_MAX_PER) begin
			lock_cnt_q   <= LOCK_RST; // R11
			dcs_locked_q <= 1'b0;
		end else if (sample_rise && per_cnt_q < last_per_q) begin
			lock_cnt_q   <= LOCK_RST; // R10
			dcs_locked_q <= 1'b0;
		end else if (lock_cnt_q == 7'(DCS_WAIT_CYC)) begin
			dcs_locked_q <= 1'b1;
		end else begin
			lock_cnt_q <= lock_cnt_q + 7'h01;
		end
	end

	// Quantize: 4 mV per code with floor rounding, clamped to the code range.
	assign diff   = $signed({pos_s_q[MV_W-1], pos_s_q}) - $signed({neg_s_q[MV_W-1], neg_s_q});
	assign code_s = (diff >>> LSB_SHIFT) + DIFF_W'(CODE_SPAN / 2);

	always_comb begin
		if (code_s >= DIFF_W'(CODE_SPAN)) begin
			bin_word = CODE_MAX; // R4
		end else if (code_s < 0) begin
			bin_word = CODE_MIN; // R5
		end else begin
			bin_word = code_s[WORD_W-1:0]; // R3 R6
		end
	end

	assign word_c = twos_q ? {~bin_word[WORD_W-1], bin_word[WORD_W-2:0]} : bin_word; // R12

	// One word per sample edge; a full buffer drops the sample and raises the stall flag.
	aofc_fifo #(
		.W     (WORD_W),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.clk       (clk),
		.srst      (srst),
		.in_valid  (sample_rise), // R12
		.in_ready  (buf_in_ready),
		.in_data   (word_c),
		.out_valid (buf_out_valid),
		.out_ready (buf_pop),
		.out_data  (buf_out_data)
	);

	assign buf_pop = (state_q == AOFC_ST_IDLE) && buf_out_valid && rdy_sync_q[1];

	always_ff @(posedge clk) begin
		if (srst) begin
			stall_q <= 1'b0;
		end else begin
			stall_q <= !buf_in_ready;
		end
	end

	// Data and forwarded clock come from the same flop bank so their delays track.
	always_ff @(posedge clk) begin
		if (srst) begin
			state_q     <= AOFC_ST_IDLE;
			phase_cnt_q <= 2'h0;
			data_q      <= CODE_MIN;
			fwd_pos_q   <= 1'b1;
			fwd_neg_q   <= 1'b0;
		end else begin
			unique case (state_q)
				AOFC_ST_IDLE: begin
					if (buf_pop) begin
						data_q      <= buf_out_data; // R8
						fwd_pos_q   <= 1'b0; // R7
						fwd_neg_q   <= 1'b1; // R7
						phase_cnt_q <= FWD_SETUP_CYC - 2'h1;
						state_q     <= AOFC_ST_SETUP;
					end
				end
				AOFC_ST_SETUP: begin
					if (phase_cnt_q == 2'h0) begin
						fwd_pos_q   <= 1'b1; // R8
						fwd_neg_q   <= 1'b0; // R7
						phase_cnt_q <= FWD_HIGH_CYC - 2'h1;
						state_q     <= AOFC_ST_HIGH;
					end else begin
						phase_cnt_q <= phase_cnt_q - 2'h1;
					end
				end
				AOFC_ST_HIGH: begin
					if (phase_cnt_q == 2'h0) begin
						state_q <= AOFC_ST_IDLE;
					end else begin
						phase_cnt_q <= phase_cnt_q - 2'h1;
					end
				end
			endcase
		end
	end

	assign data_out      = data_q;
	assign fwd_clock_pos = fwd_pos_q;
	assign fwd_clock_neg = fwd_neg_q;
	assign twos_mode     = twos_q;
	assign dcs_enabled   = dcs_en_q;
	assign dcs_locked    = dcs_locked_q;
	assign sample_stall  = stall_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	sequence s_pop;
		buf_pop;
	endsequence

	sequence s_fwd_cycle;
		!fwd_pos_q [*2] ##1 fwd_pos_q [*2];
	endsequence

	AST_FMT_BAND: assert property (sel_s_q >= BAND_HALF_MIN |=> !twos_q) // R1
		else $error("upper band did not give offset binary");

	AST_FMT_LOW: assert property (sel_s_q < BAND_HALF_MIN |=> twos_q) // R1
		else $error("lower band did not give twos complement");

	AST_DCS_BAND: assert property ((sel_s_q >= BAND_LOW_MIN && sel_s_q < BAND_TOP_MIN) |=> dcs_en_q) // R2
		else $error("middle band did not enable stabilizer");

	AST_DCS_EDGE: assert property ((sel_s_q >= BAND_TOP_MIN || sel_s_q < BAND_LOW_MIN) |=> !dcs_en_q) // R2
		else $error("outer band left stabilizer enabled");

	AST_MIDSCALE: assert property (diff == 0 |-> word_c == (twos_q ? 8'h00 : 8'h80)) // R3
		else $error("zero input not at midscale");

	AST_SAT_HIGH: assert property (diff >= 512 |-> word_c == (twos_q ? 8'h7F : 8'hFF)) // R4
		else $error("positive overrange not saturated");

	AST_SAT_LOW: assert property (diff <= -512 |-> word_c == (twos_q ? 8'h80 : 8'h00)) // R5
		else $error("negative overrange not saturated");

	AST_STEP: assert property ((diff >= 4 && diff < 8) |-> word_c == (twos_q ? 8'h01 : 8'h81)) // R6
		else $error("one step above midscale wrong");

	AST_FWD_PAIR: assert property (fwd_neg_q == !fwd_pos_q) // R7
		else $error("forwarded clock legs not complementary");

	AST_FWD_SHAPE: assert property (s_pop |=> s_fwd_cycle) // R8
		else $error("forwarded clock shape wrong after pop");

	AST_DATA_HOLD: assert property (!$stable(data_q) |-> !fwd_pos_q) // R8
		else $error("data changed while forwarded clock high");

	AST_POP_DATA: assert property (s_pop |=> data_q == $past(buf_out_data)) // R8
		else $error("popped word not presented");

	AST_LOCK_EN: assert property (dcs_locked_q |-> $past(dcs_en_q)) // R11
		else $error("locked while stabilizer disabled");

	AST_TWOS_MSB: assert property (twos_q |-> word_c == {~bin_word[7], bin_word[6:0]}) // R12
		else $error("twos word not msb-inverted binary");

	AST_ONE_PER_SAMPLE: assert property (sample_rise |=> !sample_rise) // R12
		else $error("two sample edges back to back");
endmodule
`default_nettype wire
